// *** src/ident_defines.svh ***
`ifndef IDENT_DEFINES_SVH
`define IDENT_DEFINES_SVH
// ==========================================================
// register byte offsets
`define ID_OFS_CTRL        9'h000
`define ID_OFS_MAXM        9'h004
`define ID_OFS_VAR         9'h008
`define ID_OFS_CAP         9'h00c
`define ID_OFS_STAT        9'h010
`define ID_OFS_STR         9'h100
`define ID_STR_WORDS       34
`define ID_BLOCK_WORDS     256
// ==========================================================
// control register bits
`define ID_CTRL_LOCK       0
`define ID_CTRL_REMOV      1
`define ID_CTRL_SPINUP     3
`define ID_CTRL_MEMCARD    4
`define ID_CTRL_SERIAL     5
`define ID_CTRL_STDBY      6
`define ID_CTRL_IORDY      7
`define ID_CTRL_IORDY_DIS  8
`define ID_CTRL_DMA        9
`define ID_CTRL_MINSTBY    10
`define ID_CTRL_F64        11
`define ID_CTRL_UDMA       12
`define ID_CTRL_MASK       16'h1ffb
`define ID_CTRL_RST        16'h0000
// variable register bits
`define ID_VAR_MULTI_VALID 8
`define ID_VAR_INCOMPLETE  9
`define ID_VAR_MASK        16'h03ff
`define ID_VAR_RST         16'h0000
// status register bits
`define ID_STAT_LOCK       0
`define ID_STAT_BUSY       1
`define ID_STAT_MEDIA      2
// ==========================================================
// reset values and limits
`define ID_MAXM_RST        8'h10
`define ID_CAP_RST         32'h0000_0000
`define ID_CAP_MAX         32'h00ff_ffff
`define ID_SERIAL_MAXM     8'h10
`define ID_PAD_WORD        16'h2020
// ==========================================================
// word indices and fixed word values
`define ID_WI_GCFG         8'h00
`define ID_WI_SPEC         8'h02
`define ID_WI_SER_FIRST    8'h0a
`define ID_WI_SER_LAST     8'h13
`define ID_WI_FW_FIRST     8'h17
`define ID_WI_MODEL_LAST   8'h2e
`define ID_WI_FW_SHIFT     8'h0d
`define ID_WI_MAXM         8'h2f
`define ID_WI_CAP1         8'h31
`define ID_WI_CAP2         8'h32
`define ID_WI_VALID        8'h35
`define ID_WI_MULTI        8'h3b
`define ID_WI_LBA_LO       8'h3c
`define ID_WI_LBA_HI       8'h3d
`define ID_W0_MEMCARD      16'h848a
`define ID_W0_REMOV        7
`define ID_W0_INCOMPLETE   2
`define ID_W2_SPIN_INC     16'h37c8
`define ID_W2_SPIN_CMP     16'h738c
`define ID_W2_NOSPIN_INC   16'h8c73
`define ID_W2_NOSPIN_CMP   16'hc837
`define ID_W49_STDBY       13
`define ID_W49_IORDY       11
`define ID_W49_IORDY_DIS   10
`define ID_W49_LBA         9
`define ID_W49_DMA         8
`define ID_W50_VALID       2'b01
`define ID_W50_MINSTBY     0
`define ID_W53_F64         1
`define ID_W53_UDMA        2
`define ID_W59_VALID       8
`endif

// *** src/ident_pkg.sv ***
`default_nettype none
package ident_pkg;
    typedef enum logic [2:0] {
        REG_CTRL = 3'b000,
        REG_MAXM = 3'b001,
        REG_VAR  = 3'b010,
        REG_CAP  = 3'b011,
        REG_STAT = 3'b100,
        REG_STR  = 3'b101,
        REG_NONE = 3'b110
    } reg_t;
    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_SEND = 1'b1
    } seq_t;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0]  maxm;
        logic [15:0] vset;
        logic [31:0] cap;
        logic        media;
        logic        ack;
        logic [31:0] rdat;
        logic        sync1;
        logic        sync2;
        logic        prev;
    } top_st_t;
endpackage
`default_nettype wire

// *** src/ident_if.sv ***
`default_nettype none
interface ident_if;
    logic        wr_en;
    logic [5:0]  wr_idx;
    logic [15:0] wr_data;
    logic [5:0]  a_idx;
    logic [15:0] a_data;
    logic [5:0]  b_idx;
    logic [15:0] b_data;
    logic        start;
    logic        ready;
    logic [7:0]  req_idx;
    logic [15:0] req_word;
    logic        valid;
    logic [15:0] word;
    logic [7:0]  index;
    logic        last;
    modport store (input wr_en, wr_idx, wr_data, a_idx, b_idx, output a_data, b_data);
    modport store_user (output wr_en, wr_idx, wr_data, a_idx, b_idx, input a_data, b_data);
    modport seq (input start, ready, req_word, output req_idx, valid, word, index, last);
    modport seq_user (output start, ready, req_word, input req_idx, valid, word, index, last);
endinterface
`default_nettype wire

// *** src/ident_str_store.sv ***
`include "ident_defines.svh"
`default_nettype none
module ident_str_store #(
    parameter int N = `ID_STR_WORDS
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    ident_if.store   s
);
    // index field is 6 bits, so no more than 64 words
    if (N < 1 || N > 64)
    begin : g_bad_size
        $error("string store size out of range");
    end
    logic [N-1:0][15:0] w_q;
    logic [N-1:0][15:0] w_d;
    // ==========================================================
    // storage
    always_comb
    begin
        w_d = w_q;
        if (s.wr_en && (32'(s.wr_idx) < N))
            w_d[s.wr_idx] = s.wr_data;
    end
    assign s.a_data = (32'(s.a_idx) < N) ? w_q[s.a_idx] : 16'h0000;
    assign s.b_data = (32'(s.b_idx) < N) ? w_q[s.b_idx] : 16'h0000;
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            w_q <= {N{`ID_PAD_WORD}}; // see R7 see R8 see R9
        else
            w_q <= w_d;
    end
endmodule // ident_str_store
`default_nettype wire

// *** src/ident_seq.sv ***
`include "ident_defines.svh"
`default_nettype none
module ident_seq #(
    parameter int WORDS = `ID_BLOCK_WORDS
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    ident_if.seq     s
);
    if (WORDS != 256)
    begin : g_bad_words
        $error("index port is 8 bits wide");
    end
    typedef struct packed {
        ident_pkg::seq_t st;
        logic [7:0]      idx;
        logic [15:0]     data;
    } seq_st_t;
    seq_st_t q;
    seq_st_t d;
    logic    at_last;
    // ==========================================================
    // word walk, index 0 upward
    assign at_last   = (q.idx == 8'(WORDS - 1));
    assign s.req_idx = s.start ? 8'h00 : q.idx + 8'h01;
    always_comb
    begin
        d = q;
        if (s.start)
        begin
            d.st   = ident_pkg::SEQ_SEND; // see R22
            d.idx  = 8'h00;
            d.data = s.req_word;
        end
        else
        begin
            unique case (q.st)
                ident_pkg::SEQ_IDLE: d = q;
                ident_pkg::SEQ_SEND:
                begin
                    if (s.ready && at_last)
                        d.st = ident_pkg::SEQ_IDLE;
                    else if (s.ready)
                    begin
                        d.idx  = s.req_idx; // see R22
                        d.data = s.req_word;
                    end
                end
            endcase
        end
    end
    assign s.valid = (q.st == ident_pkg::SEQ_SEND);
    assign s.word  = q.data;
    assign s.index = q.idx;
    assign s.last  = at_last;
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            q.st   <= ident_pkg::SEQ_IDLE;
            q.idx  <= 8'h00;
            q.data <= 16'h0000;
        end
        else
            q <= d;
    end
endmodule // ident_seq
`default_nettype wire

// *** src/ident_block.sv ***
`include "ident_defines.svh"
`default_nettype none
// Notes on behaviour
// R1 - word 0 bit 15 zero, except in the fixed memory-card word 0
// R2 - word 0 bit 7 marks removable media
// R3 - word 0 bit 2 marks incomplete data
// R4 - memory-card device returns fixed word 0
// R5 - spin-up needed: word 2 codes
// R6 - no spin-up: word 2 codes, others reserved
// R7 - serial number words, space padded
// R8 - firmware revision words, space padded
// R9 - model number words, space padded
// R10 - word 47 low byte, serial limit 16
// R11 - word 49 bit 13 standard standby timers
// R12 - word 49 bit 11 IORDY support
// R13 - word 49 bit 10 IORDY can be disabled
// R14 - word 49 LBA bit, DMA bit
// R15 - word 50 validity pattern 01
// R16 - word 50 bit 0 device minimum standby
// R17 - word 53 bit 1 words 64-70 valid
// R18 - word 53 bit 2 ultra DMA valid
// R19 - word 59 current multiple setting
// R20 - words 60-61 capacity, capped 0ffffff
// R21 - fixed words change only on media change
// R22 - 256 words sent in ascending order
// R23 - unused words and bits read zero
module ident_block (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [8:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic [3:0]  I_WB_SEL,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_ID_START,
    input  wire logic        I_ID_READY,
    input  wire logic        I_MEDIA_CHANGE,
    output logic             O_ID_VALID,
    output logic      [15:0] O_ID_WORD,
    output logic      [7:0]  O_ID_INDEX,
    output logic             O_ID_LAST
);
    ident_pkg::top_st_t s_q;
    ident_pkg::top_st_t s_d;
    ident_pkg::reg_t    rsel;
    ident_if            lnk ();
    logic               bus;
    logic               wr;
    logic               locked;
    logic               unlock;
    logic [31:0]        wv;
    logic [31:0]        rv;

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[8*b +: 8] = n[8*b +: 8];
        return r;
    endfunction

    function automatic ident_pkg::reg_t decode(input logic [8:0] a);
        ident_pkg::reg_t r;
        r = ident_pkg::REG_NONE;
        if (a[8])
        begin
            if (a[7:2] < 6'(`ID_STR_WORDS))
                r = ident_pkg::REG_STR;
        end
        else if ({a[8:2], 2'b00} == `ID_OFS_CTRL)
            r = ident_pkg::REG_CTRL;
        else if ({a[8:2], 2'b00} == `ID_OFS_MAXM)
            r = ident_pkg::REG_MAXM;
        else if ({a[8:2], 2'b00} == `ID_OFS_VAR)
            r = ident_pkg::REG_VAR;
        else if ({a[8:2], 2'b00} == `ID_OFS_CAP)
            r = ident_pkg::REG_CAP;
        else if ({a[8:2], 2'b00} == `ID_OFS_STAT)
            r = ident_pkg::REG_STAT;
        return r;
    endfunction

    function automatic logic [5:0] str_index(input logic [7:0] i);
        logic [7:0] k;
        k = (i <= `ID_WI_SER_LAST) ? i - `ID_WI_SER_FIRST : i - `ID_WI_FW_SHIFT;
        return k[5:0];
    endfunction

    // all words not built below stay zero: see R23
    function automatic logic [15:0] word_at(input logic [7:0] i, input logic [15:0] c, input logic [7:0] mm,
                                            input logic [15:0] v, input logic [31:0] cp, input logic [15:0] sd);
        logic [15:0] w;
        logic        mc;
        logic        sr;
        w  = 16'h0000;
        mc = c[`ID_CTRL_MEMCARD];
        sr = c[`ID_CTRL_SERIAL];
        if (i == `ID_WI_GCFG)
        begin
            if (mc)
                w = `ID_W0_MEMCARD; // see R4
            else
            begin
                w[15]                = 1'b0; // see R1
                w[`ID_W0_REMOV]      = c[`ID_CTRL_REMOV]; // see R2
                w[`ID_W0_INCOMPLETE] = v[`ID_VAR_INCOMPLETE]; // see R3
            end
        end
        else if (i == `ID_WI_SPEC)
        begin
            // word 2 always valid even when data is incomplete: see R3
            unique case ({c[`ID_CTRL_SPINUP], v[`ID_VAR_INCOMPLETE]})
                2'b11: w = `ID_W2_SPIN_INC; // see R5
                2'b10: w = `ID_W2_SPIN_CMP; // see R5
                2'b01: w = `ID_W2_NOSPIN_INC; // see R6
                2'b00: w = `ID_W2_NOSPIN_CMP; // see R6
            endcase
        end
        else if ((i >= `ID_WI_SER_FIRST && i <= `ID_WI_SER_LAST) || (i >= `ID_WI_FW_FIRST && i <= `ID_WI_MODEL_LAST))
            w = sd; // see R7 see R8 see R9
        else if (i == `ID_WI_MAXM)
            w[7:0] = (sr && mm > `ID_SERIAL_MAXM) ? `ID_SERIAL_MAXM : mm; // see R10
        else if (i == `ID_WI_CAP1)
        begin
            w[`ID_W49_STDBY]     = c[`ID_CTRL_STDBY]; // see R11
            w[`ID_W49_IORDY]     = c[`ID_CTRL_IORDY] | sr | ~mc; // see R12
            w[`ID_W49_IORDY_DIS] = c[`ID_CTRL_IORDY_DIS] | sr; // see R13
            w[`ID_W49_LBA]       = 1'b1; // see R14
            w[`ID_W49_DMA]       = c[`ID_CTRL_DMA] | ~mc; // see R14
        end
        else if (i == `ID_WI_CAP2)
        begin
            w[15:14]           = `ID_W50_VALID; // see R15
            w[`ID_W50_MINSTBY] = c[`ID_CTRL_MINSTBY]; // see R16
        end
        else if (i == `ID_WI_VALID)
        begin
            // non memory-card devices have pio mode 3, so 64-70 are valid
            w[`ID_W53_F64]  = c[`ID_CTRL_F64] | sr | ~mc; // see R17
            w[`ID_W53_UDMA] = c[`ID_CTRL_UDMA] | sr; // see R18
        end
        else if (i == `ID_WI_MULTI)
        begin
            w[`ID_W59_VALID] = v[`ID_VAR_MULTI_VALID]; // see R19
            w[7:0]           = v[`ID_VAR_MULTI_VALID] ? v[7:0] : 8'h00; // see R19
        end
        else if (i == `ID_WI_LBA_LO)
            w = cp[15:0]; // see R20
        else if (i == `ID_WI_LBA_HI)
            w = cp[31:16]; // see R20
        return w;
    endfunction

    // ==========================================================
    // submodules
    ident_str_store #(
        .N (`ID_STR_WORDS)
    ) u_store (
        .I_CLK (I_CLK),
        .I_RST (I_RST),
        .s     (lnk)
    );

    ident_seq #(
        .WORDS (`ID_BLOCK_WORDS)
    ) u_seq (
        .I_CLK (I_CLK),
        .I_RST (I_RST),
        .s     (lnk)
    );

    // ==========================================================
    // bus decode and word source
    assign bus    = I_WB_CYC & I_WB_STB & ~s_q.ack;
    assign wr     = bus & I_WB_WE;
    assign rsel   = decode(I_WB_ADR);
    assign locked = s_q.ctrl[`ID_CTRL_LOCK];
    // media change pin sampled only after two flops
    assign unlock = s_q.sync2 & ~s_q.prev & s_q.ctrl[`ID_CTRL_REMOV]; // see R21

    assign lnk.a_idx    = str_index(lnk.req_idx);
    assign lnk.b_idx    = I_WB_ADR[7:2];
    assign lnk.wr_idx   = I_WB_ADR[7:2];
    assign lnk.wr_en    = wr & (rsel == ident_pkg::REG_STR) & ~locked; // see R21
    assign lnk.wr_data  = wv[15:0];
    assign lnk.start    = I_ID_START;
    assign lnk.ready    = I_ID_READY;
    assign lnk.req_word = word_at(lnk.req_idx, s_q.ctrl, s_q.maxm, s_q.vset, s_q.cap, lnk.a_data);

    always_comb
    begin
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        unique case (rsel)
            ident_pkg::REG_CTRL: rv = {16'h0000, s_q.ctrl};
            ident_pkg::REG_MAXM: rv = {24'h00_0000, s_q.maxm};
            ident_pkg::REG_VAR:  rv = {16'h0000, s_q.vset};
            ident_pkg::REG_CAP:  rv = s_q.cap;
            ident_pkg::REG_STAT:
            begin
                rv[`ID_STAT_LOCK]  = locked;
                rv[`ID_STAT_BUSY]  = lnk.valid;
                rv[`ID_STAT_MEDIA] = s_q.media;
            end
            ident_pkg::REG_STR:  rv = {16'h0000, lnk.b_data};
            ident_pkg::REG_NONE: rv = 32'h0000_0000;
        endcase
        wv = merge(rv, I_WB_DAT, I_WB_SEL);
    end

    // ==========================================================
    // register state
    always_comb
    begin
        s_d       = s_q;
        s_d.sync1 = I_MEDIA_CHANGE;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        s_d.ack   = bus;
        s_d.rdat  = bus ? rv : 32'h0000_0000;
        if (wr && !locked)
        begin
            // fixed words frozen once locked: see R21
            if (rsel == ident_pkg::REG_CTRL)
                s_d.ctrl = wv[15:0] & `ID_CTRL_MASK;
            if (rsel == ident_pkg::REG_MAXM)
                s_d.maxm = wv[7:0];
            if (rsel == ident_pkg::REG_CAP)
                s_d.cap = (wv > `ID_CAP_MAX) ? `ID_CAP_MAX : wv; // see R20
        end
        // variable words stay writable while locked
        if (wr && rsel == ident_pkg::REG_VAR)
            s_d.vset = wv[15:0] & `ID_VAR_MASK; // see R19
        if (wr && rsel == ident_pkg::REG_STAT && I_WB_SEL[0] && I_WB_DAT[`ID_STAT_MEDIA])
            s_d.media = 1'b0;
        // media set wins over a clear in the same cycle, and the lock clear wins over a lock write
        if (unlock)
        begin
            s_d.ctrl[`ID_CTRL_LOCK] = 1'b0; // see R21
            s_d.media               = 1'b1;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            s_q.ctrl  <= `ID_CTRL_RST;
            s_q.maxm  <= `ID_MAXM_RST;
            s_q.vset  <= `ID_VAR_RST;
            s_q.cap   <= `ID_CAP_RST;
            s_q.media <= 1'b0;
            s_q.ack   <= 1'b0;
            s_q.rdat  <= 32'h0000_0000;
            s_q.sync1 <= 1'b0;
            s_q.sync2 <= 1'b0;
            s_q.prev  <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign O_WB_ACK   = s_q.ack;
    assign O_WB_DAT   = s_q.rdat;
    assign O_ID_VALID = lnk.valid;
    assign O_ID_WORD  = lnk.word;
    assign O_ID_INDEX = lnk.index;
    assign O_ID_LAST  = lnk.last;

    // ==========================================================
    // assertions
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    property p_ack;
        (I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK ##1 !O_WB_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not one cycle after request");

    property p_w0_b15;
        (O_ID_VALID && O_ID_INDEX == 8'h00 && O_ID_WORD != `ID_W0_MEMCARD) |-> !O_ID_WORD[15];
    endproperty
    a_w0_b15: assert property (p_w0_b15) else $error("word 0 bit 15 set"); // see R1

    property p_w0_mc;
        (I_ID_START && s_q.ctrl[`ID_CTRL_MEMCARD]) |=> O_ID_VALID && O_ID_INDEX == 8'h00
            && O_ID_WORD == `ID_W0_MEMCARD;
    endproperty
    a_w0_mc: assert property (p_w0_mc) else $error("memory-card word 0 wrong"); // see R4

    property p_w2;
        (O_ID_VALID && O_ID_INDEX == `ID_WI_SPEC) |-> O_ID_WORD inside {`ID_W2_SPIN_INC, `ID_W2_SPIN_CMP,
            `ID_W2_NOSPIN_INC, `ID_W2_NOSPIN_CMP};
    endproperty
    a_w2: assert property (p_w2) else $error("word 2 holds a reserved code"); // see R5 see R6

    property p_w47;
        (O_ID_VALID && O_ID_INDEX == `ID_WI_MAXM && s_q.ctrl[`ID_CTRL_SERIAL]) |-> O_ID_WORD[7:0] <= 8'h10;
    endproperty
    a_w47: assert property (p_w47) else $error("serial multiple limit exceeded"); // see R10

    property p_w49;
        (O_ID_VALID && O_ID_INDEX == `ID_WI_CAP1) |-> O_ID_WORD[`ID_W49_LBA] && O_ID_WORD[7:0] == 8'h00;
    endproperty
    a_w49: assert property (p_w49) else $error("word 49 lba bit clear"); // see R14

    property p_w50;
        (O_ID_VALID && O_ID_INDEX == `ID_WI_CAP2) |-> O_ID_WORD[15:14] == 2'b01 && O_ID_WORD[13:1] == 13'h0;
    endproperty
    a_w50: assert property (p_w50) else $error("word 50 validity pattern wrong"); // see R15

    property p_cap;
        (wr && rsel == ident_pkg::REG_CAP && !locked) |=> s_q.cap <= `ID_CAP_MAX ##1 O_WB_ACK == 1'b0;
    endproperty
    a_cap: assert property (p_cap) else $error("capacity above limit"); // see R20

    property p_lock;
        (locked && !unlock) |=> $stable(s_q.cap) && $stable(s_q.maxm) && $stable(s_q.ctrl);
    endproperty
    a_lock: assert property (p_lock) else $error("fixed field changed while locked"); // see R21

    property p_walk;
        (O_ID_VALID && I_ID_READY && !O_ID_LAST && !I_ID_START) |=> O_ID_VALID
            && O_ID_INDEX == $past(O_ID_INDEX) + 8'h01;
    endproperty
    a_walk: assert property (p_walk) else $error("word index did not step by one"); // see R22

    property p_w1;
        (O_ID_VALID && O_ID_INDEX == 8'h01) |-> O_ID_WORD == 16'h0000;
    endproperty
    a_w1: assert property (p_w1) else $error("obsolete word 1 not zero"); // see R23

    c_done:   cover property (O_ID_VALID && I_ID_READY && O_ID_LAST);
    c_memc:   cover property (I_ID_START && s_q.ctrl[`ID_CTRL_MEMCARD]);
    c_write:  cover property (wr && rsel == ident_pkg::REG_STR ##1 O_WB_ACK);
    c_unlock: cover property (unlock && locked);
endmodule // ident_block
`default_nettype wire

// *** verification/ident_host_model.sv ***
`default_nettype none
module ident_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_word,
    input  wire logic [7:0]  i_index,
    input  wire logic        i_last,
    output logic             o_start,
    output logic             o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [0:255];
    int          got = 0;
    int          bad = 0;
    int          seed = 32'hd6c3033f;
    // ==========
    // host reader: stalls at random, a restart drops any word offered with it
    always @(posedge i_clk)
    begin
        o_start <= i_go;
        o_ready <= ($random(seed) & 3) != 0;
        // last flag must mark exactly the top index
        if (i_valid && (i_last !== (i_index == 8'hff)))
            bad <= bad + 1;
        if (o_start)
            got <= 0;
        else if (i_valid && o_ready)
        begin
            if (i_index !== got[7:0])
                bad <= bad + 1;
            words[i_index] <= i_word;
            got <= got + 1;
        end
    end
endmodule // ident_host_model
`default_nettype wire

// *** verification/ident_block_tb.sv ***
`include "ident_defines.svh"
`default_nettype none
module ident_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        go;
    logic        media;
    logic        ack;
    logic        start;
    logic        ready;
    logic        valid;
    logic        last;
    logic [3:0]  sel;
    logic [7:0]  maxm;
    logic [7:0]  index;
    logic [8:0]  adr;
    logic [15:0] ctrl;
    logic [15:0] vset;
    logic [15:0] word;
    logic [31:0] dat;
    logic [31:0] rdat;
    logic [31:0] r;
    logic [31:0] cap;
    logic [15:0] str [0:33];
    int          fail_count = 0;
    int          n_checks = 0;
    int          seed = 32'hd6c3033f;
    ident_block u_dut (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_DAT(dat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ID_START(start), .I_ID_READY(ready),
        .I_MEDIA_CHANGE(media), .O_ID_VALID(valid), .O_ID_WORD(word), .O_ID_INDEX(index), .O_ID_LAST(last));
    ident_host_model u_host (.i_clk(clk), .i_go(go), .i_valid(valid), .i_word(word), .i_index(index),
        .i_last(last), .o_start(start), .o_ready(ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========
    // helpers
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic rchk(input logic [8:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    function automatic logic [15:0] exp_word(input int i);
        logic mc;
        logic sr;
        logic [31:0] ce;
        mc = ctrl[4];
        sr = ctrl[5];
        ce = (cap > 32'h00ffffff) ? 32'h00ffffff : cap;
        case (i)
            0: return mc ? 16'h848a : {8'h00, ctrl[1], 4'h0, vset[9], 2'b00};
            2: return ctrl[3] ? (vset[9] ? 16'h37c8 : 16'h738c) : (vset[9] ? 16'h8c73 : 16'hc837);
            47: return {8'h00, (sr && maxm > 8'h10) ? 8'h10 : maxm};
            49: return {2'b00, ctrl[6], 1'b0, ctrl[7] | ~mc | sr, ctrl[8] | sr, 1'b1, ctrl[9] | ~mc, 8'h00};
            50: return {2'b01, 13'h0, ctrl[10]};
            53: return {13'h0, ctrl[12] | sr, ctrl[11] | ~mc | sr, 1'b0};
            59: return vset[8] ? {8'h01, vset[7:0]} : 16'h0000;
            60: return ce[15:0];
            61: return ce[31:16];
            default: return (i >= 10 && i <= 19) || (i >= 23 && i <= 46) ? str[i < 20 ? i - 10 : i - 13] : 16'h0000;
        endcase
    endfunction
    // ==========
    // one whole block; a restart lands some twenty cycles in, mid-stream
    task automatic run_block(input bit restart);
        int n;
        n = 0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        go <= restart;
        @(posedge clk);
        go <= 1'b0;
        rchk(`ID_OFS_STAT, 32'h2);
        while ((u_host.got != 256 || valid !== 1'b0) && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000)
        begin
            fail_count++;
            finish_test();
        end
        chk(32'(u_host.got), 32'h100);
        chk(32'(u_host.bad), 32'h0);
        for (int i = 0; i < 256; i++)
            chk({16'h0, u_host.words[i]}, {16'h0, exp_word(i)});
    endtask
    task automatic chk_reset();
        rchk(`ID_OFS_CTRL, 32'h0);
        rchk(`ID_OFS_MAXM, 32'h10);
        rchk(`ID_OFS_VAR, 32'h0);
        rchk(`ID_OFS_CAP, 32'h0);
        rchk(`ID_OFS_STR, 32'h2020);
    endtask
    // ==========
    // main sequence
    initial
    begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        go = 1'b0;
        media = 1'b0;
        sel = 4'hf;
        adr = 9'h0;
        dat = 32'h0;
        ctrl = 16'h0;
        maxm = 8'h10;
        vset = 16'h0;
        cap = 32'h0;
        for (int k = 0; k < 34; k++)
            str[k] = 16'h2020;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk_reset();
        wb(1'b1, 9'h0f0, 32'hffffffff, r);
        rchk(9'h0f0, 32'h0);
        run_block(1'b0);
        for (int it = 0; it < 5; it++)
        begin
            ctrl = 16'($random(seed)) & 16'h1ffa;
            ctrl[5:4] = (it == 1) ? 2'b01 : (it[0] == 1'b0) ? 2'b10 : ctrl[5:4];
            maxm = (it == 2) ? 8'h10 : 8'($random(seed));
            vset = 16'($random(seed)) & 16'h03ff;
            cap = $random(seed);
            cap = cap >> (8 * (it & 1));
            wb(1'b1, `ID_OFS_CTRL, {16'h0, ctrl}, r);
            wb(1'b1, `ID_OFS_MAXM, {24'h0, maxm}, r);
            wb(1'b1, `ID_OFS_VAR, {16'h0, vset}, r);
            wb(1'b1, `ID_OFS_CAP, cap, r);
            for (int k = 0; k < 34; k++)
            begin
                str[k] = 16'($random(seed));
                wb(1'b1, `ID_OFS_STR + 9'(4 * k), {16'h0, str[k]}, r);
            end
            rchk(`ID_OFS_CTRL, {16'h0, ctrl});
            rchk(`ID_OFS_CAP, cap > 32'h00ffffff ? 32'h00ffffff : cap);
            run_block(it == 1);
        end
        wb(1'b1, `ID_OFS_CTRL, 32'h3, r);
        wb(1'b1, `ID_OFS_CTRL, 32'h10, r);
        wb(1'b1, `ID_OFS_MAXM, 32'h1, r);
        rchk(`ID_OFS_CTRL, 32'h3);
        rchk(`ID_OFS_MAXM, {24'h0, maxm});
        wb(1'b1, `ID_OFS_VAR, 32'h155, r);
        rchk(`ID_OFS_VAR, 32'h155);
        media <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(`ID_OFS_STAT, 32'h4);
        rchk(`ID_OFS_CTRL, 32'h2);
        wb(1'b1, `ID_OFS_STAT, 32'h4, r);
        rchk(`ID_OFS_STAT, 32'h0);
        wb(1'b1, `ID_OFS_CTRL, 32'h3, r);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk_reset();
        finish_test();
    end
endmodule // ident_block_tb
`default_nettype wire
